// [beam_word_pkg.sv]
// Constants and field types for the beam status word decoder
package beam_word_pkg;

  // Word geometry
  localparam int unsigned WORD_BITS   = 122;
  localparam int unsigned SEG_BITS    = 27;
  localparam int unsigned COMMON_BITS = 14;
  localparam int unsigned NUM_CHAN    = 4;

  // Segment start bits within the word
  localparam int unsigned CH4_BASE = 14;
  localparam int unsigned CH3_BASE = 41;
  localparam int unsigned CH2_BASE = 68;
  localparam int unsigned CH1_BASE = 95;

  // Common segment bit positions
  localparam int unsigned COM_RX_EN_POS  = 0;
  localparam int unsigned COM_TX_EN_POS  = 1;
  localparam int unsigned COM_DELAY_LSB  = 2;
  localparam int unsigned COM_DELAY_MSB  = 13;

  // Channel segment field offsets
  localparam int unsigned SEG_RX_EN_POS  = 0;
  localparam int unsigned SEG_TX_EN_POS  = 1;
  localparam int unsigned SEG_RSV0_POS   = 2;
  localparam int unsigned SEG_TX_PH_LSB  = 3;
  localparam int unsigned SEG_TX_PH_MSB  = 8;
  localparam int unsigned SEG_RX_PH_LSB  = 9;
  localparam int unsigned SEG_RX_PH_MSB  = 14;
  localparam int unsigned SEG_TX_AT_LSB  = 15;
  localparam int unsigned SEG_TX_AT_MSB  = 18;
  localparam int unsigned SEG_RSV1_LSB   = 19;
  localparam int unsigned SEG_RSV1_MSB   = 20;
  localparam int unsigned SEG_RX_AT_LSB  = 21;
  localparam int unsigned SEG_RX_AT_MSB  = 26;

  // Step sizes: phase in millidegrees, attenuation in tenths of dB
  localparam logic [18:0] PHASE_STEP_MDEG = 19'h015f9;
  localparam logic [8:0]  ATT_STEP_TENTH  = 9'h005;

  // Tally reset value and the bit count of a full word
  localparam logic [15:0] WORD_COUNT_RST = 16'h0000;
  localparam logic [7:0]  BIT_COUNT_WORD = 8'h7a;

  typedef struct packed {
    logic        rx_en;
    logic        tx_en;
    logic [5:0]  tx_phase;
    logic [5:0]  rx_phase;
    logic [3:0]  tx_att;
    logic [5:0]  rx_att;
    logic [18:0] tx_phase_mdeg;
    logic [18:0] rx_phase_mdeg;
    logic [8:0]  tx_att_tenth;
    logic [8:0]  rx_att_tenth;
    logic        rsv_err;
  } chan_fields_type;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic delay_pos;
    logic rsv_err;
  } common_fields_type;

  localparam chan_fields_type   CHAN_FIELDS_RST   = '0;
  localparam common_fields_type COMMON_FIELDS_RST = '0;

endpackage : beam_word_pkg

// [beam_seg_decoder.sv]
// One channel segment decoder with registered fields
`timescale 1ns/10ps
module beam_seg_decoder
  import beam_word_pkg::*;
(
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            load_i,
  input  wire logic [26:0]     seg_i,
  output chan_fields_type      fields_o
);

  chan_fields_type fields_r;
  chan_fields_type fields_nxt;
  logic [5:0]      tx_ph;
  logic [5:0]      rx_ph;
  logic [3:0]      tx_at;
  logic [5:0]      rx_at;

  // Field slices, lowest offset is the code's LSB
  assign tx_ph = seg_i[SEG_TX_PH_MSB:SEG_TX_PH_LSB]; // [R05] [R12]
  assign rx_ph = seg_i[SEG_RX_PH_MSB:SEG_RX_PH_LSB]; // [R06] [R12]
  assign tx_at = seg_i[SEG_TX_AT_MSB:SEG_TX_AT_LSB]; // [R07] [R12]
  assign rx_at = seg_i[SEG_RX_AT_MSB:SEG_RX_AT_LSB]; // [R09] [R12]

  // Decode; setting is code times step, high bits are active
  always_comb begin
    fields_nxt          = CHAN_FIELDS_RST;
    fields_nxt.rx_en    = seg_i[SEG_RX_EN_POS]; // [R04]
    fields_nxt.tx_en    = seg_i[SEG_TX_EN_POS]; // [R04]
    fields_nxt.tx_phase = tx_ph;
    fields_nxt.rx_phase = rx_ph;
    fields_nxt.tx_att   = tx_at;
    fields_nxt.rx_att   = rx_at;
    fields_nxt.tx_phase_mdeg = 19'(tx_ph) * PHASE_STEP_MDEG; // [R11] [R12]
    fields_nxt.rx_phase_mdeg = 19'(rx_ph) * PHASE_STEP_MDEG; // [R11] [R12]
    fields_nxt.tx_att_tenth  = 9'(tx_at) * ATT_STEP_TENTH;   // [R11] [R12]
    fields_nxt.rx_att_tenth  = 9'(rx_at) * ATT_STEP_TENTH;   // [R11] [R12]
    // Reserved zeros are checked, not trusted
    fields_nxt.rsv_err = seg_i[SEG_RSV0_POS] |
                         (|seg_i[SEG_RSV1_MSB:SEG_RSV1_LSB]); // [R04] [R08]
  end

  // Hold last accepted segment until the next good word
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fields_r <= CHAN_FIELDS_RST;
    end else if (load_i) begin
      fields_r <= fields_nxt;
    end
  end

  assign fields_o = fields_r;

endmodule : beam_seg_decoder

// [beam_word_field_decoder.sv]
// Top decoder: splits the status word into common and channel fields
`timescale 1ns/10ps

// Behaviour
// [R01] Only 122-bit words are decoded
// [R02] Four 27-bit channel segments, one 14-bit common
// [R03] Common bit0 rx enable, bit1 tx enable
// [R04] Segments at 14,41,68,95; enables, zero bit
// [R05] Offsets 3-8 transmit phase, 5.625 degree steps
// [R06] Offsets 9-14 receive phase, 5.625 degree steps
// [R07] Offsets 15-18 transmit attenuation, 0.5 dB steps
// [R08] Controller zeros offsets 19 and 20
// [R09] Offsets 21-26 receive attenuation, 0.5 dB steps
// [R10] Word bit 0 is first in, first out
// [R11] Phase/attenuation active high, delay active low
// [R12] Unsigned codes, LSB lowest, setting equals code*step
module beam_word_field_decoder
  import beam_word_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // Finished word from the shift stage, with its bit count
  input  wire logic [121:0]           word_i,
  input  wire logic [7:0]             word_bits_i,
  input  wire logic                   word_valid_i,
  // Clear for both sticky error flags
  input  wire logic                   err_clear_i,
  // Decoded fields, held until the next good word
  output chan_fields_type [3:0]       chan_o,
  output common_fields_type           common_o,
  // Per-word pulses, sticky flags and the tally
  output logic                        decoded_o,
  output logic                        rejected_o,
  output logic                        len_err_o,
  output logic                        rsv_err_o,
  output logic [15:0]                 word_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance

  // Acceptance strobes
  logic                   accept;
  logic                   reject;

  // Segment slices and per-channel decoder outputs
  logic [26:0]            seg [NUM_CHAN];
  chan_fields_type [3:0]  chan_q;

  // Common segment
  logic [11:0]            delay_bits;
  common_fields_type      common_r;
  common_fields_type      common_nxt;

  // Status registers and the reserved-bit screen
  logic [NUM_CHAN-1:0]    seg_rsv;
  logic                   rsv_hit;
  logic                   decoded_r;
  logic                   rejected_r;
  logic                   len_err_r;
  logic                   rsv_err_r;
  logic [15:0]            word_count_r;

  // Scope and limits:
  //   Serial shift and both load stages live outside this block
  //   Only a finished word and its shifted bit count arrive here
  //   Reserved bits decode as they stand; flagged, never masked
  //   Masking would hide a controller fault, flagging shows it
  //   Tally wraps, so treat it as a rolling count
  //   A level on word_valid_i decodes the same word every cycle

  // A short or long word would misplace every field, so drop it
  // Refused words leave fields and tally as they were
  assign accept = word_valid_i && (word_bits_i == BIT_COUNT_WORD); // [R01]
  assign reject = word_valid_i && (word_bits_i != BIT_COUNT_WORD); // [R01]

  ////////////////////////////////////////////////////////////////////////////
  // Segment split; index 0 is channel 1

  // Word map, bit 0 first on the wire
  //   Bits 13..0    common: rx enable, tx enable, twelve delay bits
  //   Bits 40..14   channel 4
  //   Bits 67..41   channel 3
  //   Bits 94..68   channel 2
  //   Bits 121..95  channel 1
  // Segment map, offsets from each segment base
  //   Offset 0       receive enable
  //   Offset 1       transmit enable
  //   Offset 2       must be zero, flagged when set
  //   Offsets 8..3   transmit phase code
  //   Offsets 14..9  receive phase code
  //   Offsets 18..15 transmit attenuation code
  //   Offsets 20..19 must be zero, flagged when set
  //   Offsets 26..21 receive attenuation code
  // Codes are plain binary, weight doubling upward from the base step
  // Phase step 5625 millidegrees, attenuation step 5 tenths of a dB

  // Bit 0 arrives first, so channel 4 sits low in the word
  assign seg[0] = word_i[CH1_BASE +: SEG_BITS]; // [R02] [R04] [R10]
  assign seg[1] = word_i[CH2_BASE +: SEG_BITS]; // [R02] [R04]
  assign seg[2] = word_i[CH3_BASE +: SEG_BITS]; // [R02] [R04]
  assign seg[3] = word_i[CH4_BASE +: SEG_BITS]; // [R02] [R04]

  // One decoder per channel segment
  // All four load on the same strobe, so the channels always show
  // fields of one and the same word
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      beam_seg_decoder u_seg (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .load_i    (accept),
        .seg_i     (seg[gi]),
        .fields_o  (chan_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Common segment

  // Delay control bits, shared by the sense and the zero check
  assign delay_bits = word_i[COM_DELAY_MSB:COM_DELAY_LSB];

  // Delay bits act when low; all-low means positive delay state
  always_comb begin
    common_nxt           = COMMON_FIELDS_RST;
    common_nxt.rx_en     = word_i[COM_RX_EN_POS]; // [R03]
    common_nxt.tx_en     = word_i[COM_TX_EN_POS]; // [R03]
    common_nxt.delay_pos = ~(|delay_bits);        // [R11]
    common_nxt.rsv_err   = |delay_bits;           // [R03]
  end

  // Common fields hold between good words, like the channels
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      common_r <= COMMON_FIELDS_RST;
    end else if (accept) begin
      common_r <= common_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status

  // Must-be-zero bits of each channel segment, one flag per segment
  // so a stuck controller bit can be traced to its channel
  always_comb begin
    seg_rsv = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      seg_rsv[c] = seg[c][SEG_RSV0_POS] |
                   (|seg[c][SEG_RSV1_MSB:SEG_RSV1_LSB]); // [R04] [R08]
    end
  end

  // Any nonzero reserved bit in the word now being accepted
  assign rsv_hit = accept &&
                   (common_nxt.rsv_err || (|seg_rsv)); // [R03] [R08]

  // One-cycle pulses after each word
  // A level on word_valid_i gives a pulse train, one per cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      decoded_r  <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      decoded_r  <= accept;
      rejected_r <= reject; // [R01]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags and tally

  // Sticky length error; a new event beats the clear
  // Set wins so no event slips through between a status read and
  // the clear that follows it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      len_err_r <= 1'b0;
    end else if (reject) begin
      len_err_r <= 1'b1; // [R01]
    end else if (err_clear_i) begin
      len_err_r <= 1'b0;
    end
  end

  // Sticky reserved-bit error; set also wins over clear
  // Flag names the word only; per-channel detail sits in chan_o
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rsv_err_r <= 1'b0;
    end else if (rsv_hit) begin
      rsv_err_r <= 1'b1; // [R08]
    end else if (err_clear_i) begin
      rsv_err_r <= 1'b0;
    end
  end

  // Accepted word count, wraps silently at full scale
  // Refused lengths leave it alone
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_count_r <= WORD_COUNT_RST;
    end else if (accept) begin
      word_count_r <= word_count_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  // No decode logic between the registers and the pins, so the
  // consumer sees clean timing
  assign chan_o       = chan_q;
  assign common_o     = common_r;
  assign decoded_o    = decoded_r;
  assign rejected_o   = rejected_r;
  assign len_err_o    = len_err_r;
  assign rsv_err_o    = rsv_err_r;
  assign word_count_o = word_count_r;

endmodule : beam_word_field_decoder

// [beam_word_field_decoder_chk.sv]
// Assertion checker for the beam status word decoder
`timescale 1ns/10ps
module beam_word_field_decoder_chk
  import beam_word_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [121:0] word_i,
  input wire logic [7:0]  word_bits_i,
  input wire logic        word_valid_i,
  input wire logic        err_clear_i,
  input chan_fields_type [3:0] chan_o,
  input common_fields_type common_o,
  input wire logic        decoded_o,
  input wire logic        rejected_o,
  input wire logic        len_err_o,
  input wire logic        rsv_err_o,
  input wire logic [15:0] word_count_o
);
  logic [121:0] w_q;
  // Word seen at the taking edge, compared one cycle later
  always_ff @(posedge clk_sys_i) begin
    w_q <= word_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_take; word_valid_i && word_bits_i == 8'h7a; endsequence
  sequence s_bad; word_valid_i && word_bits_i != 8'h7a; endsequence
  //////////////////////////////////////////////////////////////////////////
  a_accept_pulse: assert property (
    s_take |=> decoded_o && !rejected_o) else $error("no decode pulse");
  a_reject_pulse: assert property (
    s_bad |=> rejected_o && !decoded_o && len_err_o) else $error("no reject");
  a_count_step: assert property (
    s_take |=> word_count_o == $past(word_count_o) + 16'h0001)
    else $error("word count step");
  a_common_enable: assert property (
    s_take |=> common_o.rx_en == w_q[0] && common_o.tx_en == w_q[1])
    else $error("common enables");
  a_phase_fields: assert property (
    s_take |=> chan_o[0].tx_phase == w_q[103:98]
      && chan_o[3].rx_phase == w_q[28:23]) else $error("phase field");
  a_att_fields: assert property (
    s_take |=> chan_o[2].tx_att == w_q[59:56]
      && chan_o[1].rx_att_tenth == w_q[94:89] * ATT_STEP_TENTH)
    else $error("attenuation field");
  a_delay_sense: assert property (
    decoded_o |-> common_o.delay_pos == (w_q[13:2] == 12'h000))
    else $error("delay sense");
  // Skips the first edge after reset, where old values are still sampled
  a_fields_held: assert property (
    !decoded_o && !$past(rst_i) |-> $stable(chan_o) && $stable(word_count_o))
    else $error("fields moved");
  a_rsv_flag: assert property (
    s_take ##0 (word_i[115:114] != 2'b00) |=>
      rsv_err_o && chan_o[0].rsv_err) else $error("reserved flag");
  a_flag_clear: assert property (
    err_clear_i && !word_valid_i |=> !len_err_o && !rsv_err_o)
    else $error("flag clear");
endmodule : beam_word_field_decoder_chk

bind beam_word_field_decoder beam_word_field_decoder_chk u_chk (.clk_sys_i,
  .rst_i, .word_i, .word_bits_i, .word_valid_i, .err_clear_i, .chan_o,
  .common_o, .decoded_o, .rejected_o, .len_err_o, .rsv_err_o, .word_count_o);

// [beam_ctrl_model.sv]
// Beam controller model that presents whole status words to the decoder
`timescale 1ns/10ps
module beam_ctrl_model (
  input  wire logic   clk_sys_i,
  output logic [121:0] word_o,
  output logic [7:0]  bits_o,
  output logic        valid_o
);
  initial begin
    word_o = '0;
    bits_o = 8'h00;
    valid_o = 1'b0;
  end
  // One-cycle offer; word bit 0 is the first bit on the wire
  task automatic send(input logic [121:0] w, input logic [7:0] n);
    @(posedge clk_sys_i);
    word_o <= w;   // Reserved bits as the caller commands
    bits_o <= n;   // Full length unless a refusal is wanted
    valid_o <= 1'b1;
    @(posedge clk_sys_i);
    valid_o <= 1'b0;
    // Released lines must not keep showing the old word
    word_o <= ~w;
    bits_o <= ~n;
  endtask : send
endmodule : beam_ctrl_model

// [beam_word_field_decoder_test.sv]
// Self-checking bench for the beam status word decoder
`timescale 1ns/10ps
module beam_word_field_decoder_test;
  import beam_word_pkg::*;
  logic clk_sys_i, rst_i, err_clear_i, word_valid_i;
  logic [121:0] word_i, w;
  logic [7:0] word_bits_i;
  chan_fields_type [3:0] chan_o;
  common_fields_type common_o;
  logic decoded_o, rejected_o, len_err_o, rsv_err_o;
  logic [15:0] word_count_o;
  logic [5:0] tp [4], rp [4], ra [4];
  logic [3:0] ta [4];
  int errors, checks_done;
  beam_ctrl_model u_beam_ctrl_model (.clk_sys_i, .word_o(word_i),
    .bits_o(word_bits_i), .valid_o(word_valid_i));
  beam_word_field_decoder u_beam_word_field_decoder (.clk_sys_i, .rst_i,
    .word_i, .word_bits_i, .word_valid_i, .err_clear_i, .chan_o,
    .common_o, .decoded_o, .rejected_o, .len_err_o, .rsv_err_o,
    .word_count_o);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // Offer w, then let the answer settle
  task automatic put(input logic [7:0] n);
    u_beam_ctrl_model.send(w, n);
    #1;
  endtask : put
  // One-cycle clear of the sticky flags
  task automatic clear;
    @(posedge clk_sys_i);
    err_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    err_clear_i <= 1'b0;
    #1;
  endtask : clear
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    err_clear_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Each channel its own codes, so a swapped segment shows
    for (int p = 0; p < 4; p++) begin
      w = '0;
      w[1:0] = 2'(p);
      for (int i = 0; i < 4; i++) begin
        tp[i] = 6'(p * 21 + i);
        rp[i] = 6'(63 - p * 9 - i);
        ta[i] = 4'(p * 5 + i);
        ra[i] = 6'(p * 17 + i * 3);
        w[95 - 27 * i +: 27] = {ra[i], 2'b00, ta[i], rp[i], tp[i], 1'b0,
          tp[i][0], rp[i][0]};
      end
      put(8'h7a);
      chk({decoded_o, word_count_o}, {1'b1, 16'(p + 1)});
      chk(common_o, {p[0], p[1], 2'b10});
      for (int i = 0; i < 4; i++) begin
        chk(chan_o[i][80:57], {rp[i][0], tp[i][0], tp[i], rp[i], ta[i],
          ra[i]});
        chk(chan_o[i].tx_phase_mdeg, tp[i] * 19'h015f9);
        chk(chan_o[i].rx_att_tenth, ra[i] * 9'h005);
        chk(chan_o[i].rx_phase_mdeg, rp[i] * 19'h015f9);
        chk(chan_o[i].tx_att_tenth, ta[i] * 9'h005);
      end
      @(posedge clk_sys_i);
      #1 chk(decoded_o, 1'b0);
      $display("field word %0d done", p);
    end
    // Reserved bits decode but raise the flag until cleared
    w[2] = 1'b1;
    w[114] = 1'b1;
    put(8'h7a);
    chk({common_o, rsv_err_o}, 5'b11011);
    chk(chan_o[0].rsv_err, 1'b1);
    clear();
    chk(rsv_err_o, 1'b0);
    $display("reserved test done");
    // Lengths one short and one long are refused, fields kept
    w = ~w;
    for (int n = 0; n < 2; n++) begin
      put(n ? 8'h7b : 8'h79);
      chk({rejected_o, len_err_o, decoded_o}, 3'b110);
      chk({word_count_o, chan_o[0].tx_phase}, {16'h0005, tp[0]});
    end
    clear();
    chk(len_err_o, 1'b0);
    $display("length test done");
    // Mid-run reset clears everything; a word may follow at once
    put(8'h79);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk({common_o, decoded_o, rejected_o, len_err_o, rsv_err_o,
      word_count_o}, 64'h0);
    chk(|chan_o, 1'b0);
    put(8'h7a);
    chk({decoded_o, word_count_o}, {1'b1, 16'h0001});
    $display("reset test done");
    test_done();
  end
endmodule : beam_word_field_decoder_test
